// ===== core/ebpm_pkg.sv
package ebpm_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [8:0] ADDR_CSA = 9'h11C;
  localparam logic [31:0] CSA_RESET = 32'h00010000;
  localparam logic [31:0] CSA_WMASK = 32'h0003013A;
  localparam int CSA_CS1_BIT = 1;
  localparam int CSA_CS3_BIT = 3;
  localparam int CSA_CS4_BIT = 4;
  localparam int CSA_CS5_BIT = 5;
  localparam int CSA_PULLUP_BIT = 8;
  localparam int CSA_VSEL_BIT = 16;
  localparam int CSA_SLEW_BIT = 17;

  // ---------------------------------------------------------------
  // Pin widths and chip select numbers
  // ---------------------------------------------------------------
  localparam int ADDR_W = 26;
  localparam int NUM_CS = 8;
  localparam int CS_DRAM = 1;
  localparam int CS_NAND = 3;
  localparam int CS_CARD0 = 4;
  localparam int CS_CARD1 = 5;

  // ---------------------------------------------------------------
  // Shared address field positions
  // ---------------------------------------------------------------
  localparam int PIN_LO_LSB = 2;
  localparam int PIN_LO_MSB = 11;
  localparam int DRAM_LO_LSB = 0;
  localparam int DRAM_LO_MSB = 9;
  localparam int DRAM_A10_BIT = 10;
  localparam int PIN_HI_LSB = 13;
  localparam int PIN_HI_MSB = 14;
  localparam int DRAM_HI_LSB = 11;
  localparam int DRAM_HI_MSB = 12;

  typedef enum logic {EBPM_OWNER_STATIC, EBPM_OWNER_DRAM} ebpm_owner_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [NUM_CS-1:0] cs_n;
    logic rd_n;
    logic wr0_n;
    logic wr1_n;
    logic active;
  } ebpm_static_t;

  typedef struct packed {
    logic [12:0] addr;
    logic cs_n;
    logic bm1_n;
    logic active;
  } ebpm_dram_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic dram_addr10_pin;
    logic [NUM_CS-1:0] chip_select_n;
    logic write_strobe1_n;
    logic nand_select_n;
    logic nand_read_enable_n;
    logic nand_write_enable_n;
    logic card_cs0_n;
    logic card_cs1_n;
    logic card_oe_n;
    logic card_we_n;
  } ebpm_pins_t;

  typedef struct packed {
    logic [31:0] csa;
    logic [31:0] rdata;
    ebpm_owner_t owner;
    ebpm_pins_t pins;
  } ebpm_state_t;

endpackage

// ===== core/ebpm_mux.sv
// Notes on behaviour
// - Select 1 goes to DRAM when bit set
// - Select 3 bit enables NAND glue
// - Select 4 bit enables card slot 0
// - Select 5 bit enables card slot 1
// - Pull-up bit low enables data pull-ups
// - Voltage bit: 0 is 1.8V, 1 is 3.3V
// - 26-bit address, eight low selects, 16/32 data
// - Eight devices, each with own select space
// - Shared pins follow the active controller
// - Pins 11:2 carry DRAM 9:0 or static
// - Dram address-10 pin from DRAM only
// - Pins 14:13 carry DRAM 12:11 or static
// - Write-1 pin carries DRAM mask or static
// - Pins 0,1,12,15-25 static controller only
// - NAND select, read and write strobes provided
module ebpm_mux
  import ebpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [31:0] reg_rdata,
  input wire ebpm_static_t smc_in,
  input wire ebpm_dram_t dram_in,
  output ebpm_pins_t pins,
  output logic data_pullup_enable,
  output logic memory_voltage_select,
  output logic pad_slew_select
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  ebpm_state_t st;
  ebpm_state_t next_st;

  logic cs1_dram_assign;
  logic cs3_nand_glue_enable;
  logic cs4_card_slot0_enable;
  logic cs5_card_slot1_enable;

  assign cs1_dram_assign = st.csa[CSA_CS1_BIT];
  assign cs3_nand_glue_enable = st.csa[CSA_CS3_BIT];
  assign cs4_card_slot0_enable = st.csa[CSA_CS4_BIT];
  assign cs5_card_slot1_enable = st.csa[CSA_CS5_BIT];

  // ---------------------------------------------------------------
  // Register access decode
  // ---------------------------------------------------------------
  logic csa_hit;
  logic csa_write;
  logic csa_read;
  logic [31:0] csa_wvalue;

  assign csa_hit = (reg_addr == ADDR_CSA);
  assign csa_write = reg_write && csa_hit;
  assign csa_read = reg_read && csa_hit;
  assign csa_wvalue = reg_wdata & CSA_WMASK;

  // ---------------------------------------------------------------
  // Controller decode
  // ---------------------------------------------------------------
  logic dram_route;
  logic smc_route;
  logic nand_hit;
  logic card0_hit;
  logic card1_hit;
  logic card_hit;

  assign dram_route = dram_in.active && cs1_dram_assign;
  assign smc_route = smc_in.active && !dram_route;
  assign nand_hit = cs3_nand_glue_enable && !smc_in.cs_n[CS_NAND];
  assign card0_hit = cs4_card_slot0_enable && !smc_in.cs_n[CS_CARD0];
  assign card1_hit = cs5_card_slot1_enable && !smc_in.cs_n[CS_CARD1];
  assign card_hit = card0_hit || card1_hit;

  // ---------------------------------------------------------------
  // Address routing
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addr_route;
  logic [PIN_LO_MSB-PIN_LO_LSB:0] addr_lo;
  logic [PIN_HI_MSB-PIN_HI_LSB:0] addr_hi;
  logic addr10;

  always_comb begin
    if (dram_route) begin
      addr_lo = dram_in.addr[DRAM_LO_MSB:DRAM_LO_LSB];
      addr_hi = dram_in.addr[DRAM_HI_MSB:DRAM_HI_LSB];
    end else begin
      addr_lo = smc_in.addr[PIN_LO_MSB:PIN_LO_LSB];
      addr_hi = smc_in.addr[PIN_HI_MSB:PIN_HI_LSB];
    end
  end

  always_comb begin
    addr_route = smc_in.addr;
    addr_route[PIN_LO_MSB:PIN_LO_LSB] = addr_lo;
    addr_route[PIN_HI_MSB:PIN_HI_LSB] = addr_hi;
  end

  assign addr10 = dram_in.addr[DRAM_A10_BIT];

  // ---------------------------------------------------------------
  // Select and strobe routing
  // ---------------------------------------------------------------
  logic [NUM_CS-1:0] cs_route;
  logic wr1_route;

  always_comb begin
    cs_route = smc_in.cs_n;
    if (cs1_dram_assign) begin
      cs_route[CS_DRAM] = dram_in.cs_n;
    end else begin
      cs_route[CS_DRAM] = smc_in.cs_n[CS_DRAM];
    end
  end

  always_comb begin
    if (dram_route) begin
      wr1_route = dram_in.bm1_n;
    end else begin
      wr1_route = smc_in.wr1_n;
    end
  end

  // ---------------------------------------------------------------
  // NAND and card glue
  // ---------------------------------------------------------------
  logic nand_re_route;
  logic nand_we_route;
  logic card_oe_route;
  logic card_we_route;

  always_comb begin
    if (nand_hit) begin
      nand_re_route = smc_in.rd_n;
      nand_we_route = smc_in.wr0_n;
    end else begin
      nand_re_route = 1'b1;
      nand_we_route = 1'b1;
    end
  end

  always_comb begin
    if (card_hit) begin
      card_oe_route = smc_in.rd_n;
      card_we_route = smc_in.wr0_n;
    end else begin
      card_oe_route = 1'b1;
      card_we_route = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;

    // Register port
    next_st.rdata = '0;
    if (csa_write) begin
      next_st.csa = csa_wvalue;
    end
    if (csa_read) begin
      next_st.rdata = st.csa;
    end

    // Owner tracks the controller running the current access
    if (dram_route) begin
      next_st.owner = EBPM_OWNER_DRAM;
    end else if (smc_route) begin
      next_st.owner = EBPM_OWNER_STATIC;
    end

    // Shared pins follow the active controller
    next_st.pins.addr = addr_route;
    next_st.pins.dram_addr10_pin = addr10;
    next_st.pins.chip_select_n = cs_route;
    next_st.pins.write_strobe1_n = wr1_route;

    // NAND glue on select 3
    next_st.pins.nand_select_n = !nand_hit;
    next_st.pins.nand_read_enable_n = nand_re_route;
    next_st.pins.nand_write_enable_n = nand_we_route;

    // Card glue on selects 4 and 5
    next_st.pins.card_cs0_n = !card0_hit;
    next_st.pins.card_cs1_n = !card1_hit;
    next_st.pins.card_oe_n = card_oe_route;
    next_st.pins.card_we_n = card_we_route;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      st.csa <= CSA_RESET;
      st.rdata <= '0;
      st.owner <= EBPM_OWNER_STATIC;
      st.pins.addr <= '0;
      st.pins.dram_addr10_pin <= 1'b0;
      st.pins.chip_select_n <= '1;
      st.pins.write_strobe1_n <= 1'b1;
      st.pins.nand_select_n <= 1'b1;
      st.pins.nand_read_enable_n <= 1'b1;
      st.pins.nand_write_enable_n <= 1'b1;
      st.pins.card_cs0_n <= 1'b1;
      st.pins.card_cs1_n <= 1'b1;
      st.pins.card_oe_n <= 1'b1;
      st.pins.card_we_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata = st.rdata;
  assign pins = st.pins;
  logic data_pullup_disable;

  assign data_pullup_disable = st.csa[CSA_PULLUP_BIT];
  assign data_pullup_enable = !data_pullup_disable;
  assign memory_voltage_select = st.csa[CSA_VSEL_BIT];
  assign pad_slew_select = st.csa[CSA_SLEW_BIT];

endmodule

// ===== sim/ebpm_mux_checker.sv
module ebpm_mux_checker
  import ebpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic [8:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire ebpm_static_t smc_in,
  input wire ebpm_dram_t dram_in,
  input wire ebpm_pins_t pins,
  input wire logic data_pullup_enable,
  input wire logic memory_voltage_select
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] csa;
  logic dr;
  assign dr = csa[1] && dram_in.active;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      csa <= CSA_RESET;
    end else if (reg_write && reg_addr == ADDR_CSA) begin
      csa <= reg_wdata & CSA_WMASK;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  a_dram_lo: assert property (dr |=> pins.addr[11:2] == $past(dram_in.addr[9:0]))
    else $error("dram low address");
  a_dram_hi: assert property (dr |=> pins.addr[14:13] == $past(dram_in.addr[12:11]))
    else $error("dram high address");
  a_dram_mask: assert property (dr |=> pins.write_strobe1_n == $past(dram_in.bm1_n))
    else $error("byte mask route");
  a_static_mid: assert property (!dr |=> pins.addr[14:2] == $past(smc_in.addr[14:2]))
    else $error("static address route");
  a_static_top: assert property (1 |=> pins.addr[25:15] == $past(smc_in.addr[25:15]))
    else $error("static top address");
  a_addr10_pin: assert property (1 |=> pins.dram_addr10_pin == $past(dram_in.addr[10]))
    else $error("address 10 pin");
  a_nand_glue: assert property (csa[3] && !smc_in.cs_n[3] |=> !pins.nand_select_n)
    else $error("nand select");
  a_card_one: assert property (csa[4] && !smc_in.cs_n[4] |=> !pins.card_cs0_n)
    else $error("card slot 0");
  a_card_two: assert property (csa[5] && !smc_in.cs_n[5] |=> !pins.card_cs1_n)
    else $error("card slot 1");
  a_pad_ctl: assert property (data_pullup_enable != csa[8] && memory_voltage_select == csa[16])
    else $error("pad controls");
  a_cs1_owner: assert property (csa[1] |=> pins.chip_select_n[1] == $past(dram_in.cs_n))
    else $error("select 1 owner");
  a_nand_strobe: assert property (csa[3] && !smc_in.cs_n[3] |=> pins.nand_read_enable_n == $past(smc_in.rd_n))
    else $error("nand read strobe");
  cover property (dr);
  cover property (csa[3] && !smc_in.cs_n[3]);
  cover property (csa[4] && csa[5]);
endmodule

// ===== sim/ebpm_mem_model.sv
module ebpm_mem_model
  import ebpm_pkg::*;
(
  input wire logic ref_clk,
  input wire ebpm_pins_t pins,
  output logic [25:0] seen
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge ref_clk) begin
    if (!(&pins.chip_select_n)) begin
      seen <= pins.addr;
    end
  end
endmodule

// ===== sim/ebpm_mux_tb.sv
module ebpm_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ebpm_pkg::*;
  logic ref_clk = 1'b0, srst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [31:0] reg_wdata = 32'h00000000, reg_rdata;
  ebpm_static_t smc_in = '1;
  ebpm_dram_t dram_in = '0;
  ebpm_pins_t pins;
  logic data_pullup_enable, memory_voltage_select, pad_slew_select;
  logic [25:0] seen;
  int err_count = 0, n_tests = 0;
  always #12.5 ref_clk = ~ref_clk;
  ebpm_mux i_ebpm_mux(.ref_clk, .srst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .smc_in, .dram_in, .pins, .data_pullup_enable, .memory_voltage_select, .pad_slew_select);
  ebpm_mem_model i_ebpm_mem_model(.ref_clk, .pins, .seen);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  task automatic put(input ebpm_static_t s, input ebpm_dram_t d);
    @(posedge ref_clk);
    smc_in <= s;
    dram_in <= d;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic t_regs;
    rd(ADDR_CSA, CSA_RESET);
    @(posedge ref_clk);
    #1;
    chk("rdata idle", 32'h00000000, reg_rdata);
    chk("pads", 3'b110, {data_pullup_enable, memory_voltage_select, pad_slew_select});
    wr(ADDR_CSA, 32'hFFFFFFFF);
    wr(9'h120, 32'h00000000);
    rd(ADDR_CSA, CSA_WMASK);
    rd(9'h120, 32'h00000000);
    chk("pads", 3'b011, {data_pullup_enable, memory_voltage_select, pad_slew_select});
  endtask
  task automatic t_route;
    wr(ADDR_CSA, 32'h00000000);
    put('{26'h2ABCDEF, 8'hFE, 1'b1, 1'b1, 1'b1, 1'b1}, '{13'h1555, 1'b0, 1'b0, 1'b1});
    chk("addr", 32'h02ABCDEF, pins.addr);
    chk("cs", 8'hFE, pins.chip_select_n);
    chk("wr1", 2'b11, {pins.write_strobe1_n, pins.dram_addr10_pin});
    wr(ADDR_CSA, 32'h00000002);
    @(posedge ref_clk);
    #1;
    chk("seen", 32'h02ABCDEF, seen);
    chk("dlo", 10'h155, pins.addr[11:2]);
    chk("dhi", 2'b10, pins.addr[14:13]);
    chk("cs", 8'hFC, pins.chip_select_n);
    chk("bm1", 1'b0, pins.write_strobe1_n);
  endtask
  task automatic t_glue;
    wr(ADDR_CSA, 32'h00000038);
    put('{26'h0, 8'hC7, 1'b0, 1'b1, 1'b1, 1'b1}, '0);
    chk("glue", 7'b0000101, {pins.nand_select_n, pins.card_cs0_n, pins.card_cs1_n,
      pins.nand_read_enable_n, pins.nand_write_enable_n, pins.card_oe_n, pins.card_we_n});
    wr(ADDR_CSA, 32'h00000000);
    @(posedge ref_clk);
    #1;
    chk("off", 3'b111, {pins.nand_select_n, pins.card_cs0_n, pins.card_cs1_n});
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    t_regs();
    t_route();
    t_glue();
    close_out();
  end
endmodule
bind ebpm_mux ebpm_mux_checker i_ebpm_mux_checker(.ref_clk, .srst, .reg_addr, .reg_wdata,
  .reg_write, .smc_in, .dram_in, .pins, .data_pullup_enable, .memory_voltage_select);
